// file: rtl/pic_master.sv
/*
 * Two-wire bus master that reads and writes the byte registers of a
 * power-management device. Assumes open-drain pads with pull-ups outside;
 * the serial clock is made here by a divider of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01: Data stable while clock high
// R02: Device aborts on data change mid-high
// R03: Eight bits, MSB first, then acknowledge
// R04: Device detects start and stop edges
// R05: Only master makes start and stop
// R06: Repeated start begins fresh address byte
// R07: Transmitter releases data on ninth clock
// R08: Receiver holds data low for acknowledge
// R09: Master leaves data high after last
// R10: Device answers only address 1111110
// R11: Eighth bit: one read, zero write
// R12: Device ignores transaction on address mismatch
// R13: Write sends register address then data
// R14: Device pointer increments per written byte
// R15: Master ends write with stop
// R16: Read: address write, repeated start, read
// R17: Master acknowledge advances read pointer
// R18: Read ends with not-acknowledge then stop
// R19: Device sees bus busy start to stop
// R20: Device never drives clock line
// R21: Device synchronises both lines; the device model reads both lines raw, and pic_master synchronises only sda_i
module pic_master
	import pic_pkg::*;
#(
	parameter int unsigned QTR_CYCLES = QTR_CYC,
	parameter logic [6:0] SLAVE_ADDR = DEV_ADDR
)
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_reg_i,
	input wire logic [7:0] cmd_len_i,
	output logic cmd_ready_o,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic done_o,
	output logic err_o,
	output logic busy_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic scl_o,
	output logic scl_oe_o
);
	localparam int QW = $clog2(QTR_CYCLES + 1);
	localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYCLES - 1);

	pic_state_t state_reg;
	pic_role_t role_reg;
	logic [QW-1:0] qtr_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [7:0] left_reg;
	logic [7:0] reg_addr_reg;
	logic wr_mode_reg;
	logic need_wr_reg;
	logic first_reg;
	logic ack_lo_reg;
	logic abort_reg;
	logic cmd_ready_reg;
	logic rd_valid_reg;
	logic [7:0] rd_data_reg;
	logic done_reg;
	logic busy_reg;
	logic sda_oe_reg;
	logic scl_oe_reg;
	logic sda_s;
	logic tick;
	logic step;
	logic byte_end;
	logic rx_role;
	logic sda_oe_next;
	logic scl_oe_next;

	pic_sync u_sda_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.async_i(sda_i),
		.sync_o(sda_s)
	);

	assign tick = (state_reg != ST_IDLE) && !need_wr_reg && (qtr_reg == QTR_LAST);
	assign step = tick && (phase_reg == PH_LAST);
	assign byte_end = step && (state_reg == ST_BIT) && (bit_reg == ACK_BIT_IDX);
	assign rx_role = (role_reg == ROLE_RDATA);

	// Line levels per state and quarter
	always_comb
	begin
		scl_oe_next = 1'b0;
		sda_oe_next = 1'b0;
		case (state_reg)
			ST_START:
			begin
				// R05: falling data while clock high
				scl_oe_next = (phase_reg == PH_LAST);
				sda_oe_next = (phase_reg != PH_LOW);
			end
			ST_RSTART:
			begin
				// R06: fresh start without a stop
				scl_oe_next = (phase_reg == PH_LOW) || (phase_reg == PH_LAST);
				sda_oe_next = (phase_reg == PH_SAMPLE) || (phase_reg == PH_LAST);
			end
			ST_BIT:
			begin
				// R01: data changes only in the low quarter
				scl_oe_next = (phase_reg == PH_LOW) || (phase_reg == PH_LAST);
				if (bit_reg == ACK_BIT_IDX)
					// R07 R08 R09: ack slot drive or release
					sda_oe_next = rx_role && (left_reg > 8'h01);
				else
					// R03: most significant bit first
					sda_oe_next = !rx_role && !tx_reg[3'h7 - bit_reg[2:0]];
			end
			ST_STOP:
			begin
				// R05: rising data while clock high
				scl_oe_next = (phase_reg == PH_LOW);
				sda_oe_next = (phase_reg == PH_LOW) || (phase_reg == PH_RISE);
			end
			default:
			begin
				scl_oe_next = 1'b0;
				sda_oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
		end
	end

	// Quarter-period divider; frozen while waiting for write data
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			qtr_reg <= '0;
		else if ((state_reg == ST_IDLE) || need_wr_reg || tick)
			qtr_reg <= '0;
		else
			qtr_reg <= qtr_reg + 1'b1;
	end

	// Sampling while the clock is high
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			first_reg <= 1'b1;
			ack_lo_reg <= 1'b0;
			rx_reg <= '0;
		end
		else if (tick && (state_reg == ST_BIT))
		begin
			if (phase_reg == PH_RISE)
				first_reg <= sda_s;
			else if (phase_reg == PH_SAMPLE)
			begin
				if (bit_reg == ACK_BIT_IDX)
					ack_lo_reg <= !sda_s;
				else
					rx_reg <= {rx_reg[6:0], sda_s};
			end
		end
	end

	// Main sequencer
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= ST_IDLE;
			role_reg <= ROLE_ADDR_W;
			phase_reg <= PH_LOW;
			bit_reg <= '0;
			tx_reg <= '0;
			left_reg <= '0;
			reg_addr_reg <= '0;
			wr_mode_reg <= 1'b0;
			need_wr_reg <= 1'b0;
			abort_reg <= 1'b0;
			cmd_ready_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= '0;
		end
		else
		begin
			done_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			if (tick)
				phase_reg <= phase_reg + 2'h1;
			if (need_wr_reg && wr_valid_i)
			begin
				tx_reg <= wr_data_i;
				need_wr_reg <= 1'b0;
			end
			// Line disturbed while clock high: go to stop after the byte's acknowledge slot
			if (tick && (state_reg == ST_BIT) && (phase_reg == PH_SAMPLE))
			begin
				if ((bit_reg == ACK_BIT_IDX) != rx_role)
				begin
					if (sda_s != first_reg)
						abort_reg <= 1'b1;
				end
				else if (!sda_oe_reg && !sda_s)
					abort_reg <= 1'b1;
			end
			case (state_reg)
				ST_IDLE:
				begin
					cmd_ready_reg <= 1'b1;
					phase_reg <= PH_LOW;
					if (cmd_valid_i && cmd_ready_reg)
					begin
						cmd_ready_reg <= 1'b0;
						busy_reg <= 1'b1;
						abort_reg <= 1'b0;
						wr_mode_reg <= cmd_write_i;
						reg_addr_reg <= cmd_reg_i;
						left_reg <= (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
						state_reg <= ST_START;
					end
				end
				ST_START:
				begin
					if (step)
					begin
						// R11: address with direction zero first
						state_reg <= ST_BIT;
						role_reg <= ROLE_ADDR_W;
						tx_reg <= {SLAVE_ADDR, DIR_WRITE};
						bit_reg <= '0;
					end
				end
				ST_RSTART:
				begin
					if (step)
					begin
						// R16: address resent with direction one
						state_reg <= ST_BIT;
						role_reg <= ROLE_ADDR_R;
						tx_reg <= {SLAVE_ADDR, DIR_READ};
						bit_reg <= '0;
					end
				end
				ST_STOP:
				begin
					if (step)
					begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
				ST_BIT:
				begin
					if (step && (bit_reg != ACK_BIT_IDX))
					begin
						bit_reg <= bit_reg + 4'h1;
						if (rx_role && (bit_reg == LAST_DATA_BIT))
						begin
							rd_data_reg <= rx_reg;
							rd_valid_reg <= 1'b1;
						end
					end
					else if (step)
					begin
						bit_reg <= '0;
						if (abort_reg || (!rx_role && !ack_lo_reg))
						begin
							abort_reg <= 1'b1;
							state_reg <= ST_STOP;
						end
						else
						begin
							case (role_reg)
								ROLE_ADDR_W:
								begin
									// R13: register address follows
									role_reg <= ROLE_REG;
									tx_reg <= reg_addr_reg;
								end
								ROLE_REG:
								begin
									if (wr_mode_reg)
									begin
										role_reg <= ROLE_WDATA;
										need_wr_reg <= 1'b1;
									end
									else
										// R16: repeated start for read
										state_reg <= ST_RSTART;
								end
								ROLE_WDATA:
								begin
									if (left_reg > 8'h01)
									begin
										left_reg <= left_reg - 8'h01;
										need_wr_reg <= 1'b1;
									end
									else
										// R15: stop after last data byte
										state_reg <= ST_STOP;
								end
								ROLE_ADDR_R:
									role_reg <= ROLE_RDATA;
								default:
								begin
									if (left_reg > 8'h01)
										left_reg <= left_reg - 8'h01;
									else
										// R18: not-acknowledge then stop
										state_reg <= ST_STOP;
								end
							endcase
						end
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign cmd_ready_o = cmd_ready_reg;
	assign wr_ready_o = need_wr_reg;
	assign rd_data_o = rd_data_reg;
	assign rd_valid_o = rd_valid_reg;
	assign done_o = done_reg;
	assign err_o = abort_reg;
	assign busy_o = busy_reg;
	assign sda_o = 1'b0;
	assign scl_o = 1'b0;
	assign sda_oe_o = sda_oe_reg;
	assign scl_oe_o = scl_oe_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_sda_stable_high: assert property ( // R01
		(state_reg == ST_BIT && phase_reg == PH_SAMPLE) |-> $stable(sda_oe_reg))
		else $error("data line moved while clock high");
	a_msb_first_order: assert property ( // R03
		(state_reg == ST_BIT && bit_reg < ACK_BIT_IDX && !rx_role && phase_reg != PH_LOW
			&& !need_wr_reg) |-> (sda_oe_reg == !tx_reg[3'h7 - bit_reg[2:0]]))
		else $error("transmitted bit not in msb-first order");
	a_start_stop_master: assert property ( // R05
		(!scl_oe_reg && $past(!scl_oe_reg) && $changed(sda_oe_reg))
			|-> (state_reg inside {ST_START, ST_RSTART, ST_STOP}))
		else $error("start or stop outside start/stop states");
	a_rstart_new_addr: assert property ( // R06
		(state_reg == ST_RSTART && step)
			|=> (state_reg == ST_BIT && role_reg == ROLE_ADDR_R && tx_reg == {SLAVE_ADDR, DIR_READ}))
		else $error("repeated start not followed by read address");
	a_ack_slot_release: assert property ( // R07
		(state_reg == ST_BIT && bit_reg == ACK_BIT_IDX && !rx_role && phase_reg != PH_LOW)
			|-> !sda_oe_reg)
		else $error("data line held during device acknowledge");
	a_master_ack_low: assert property ( // R08
		(state_reg == ST_BIT && bit_reg == ACK_BIT_IDX && rx_role && left_reg > 8'h01
			&& phase_reg == PH_RISE) |-> sda_oe_reg [*2])
		else $error("master acknowledge not held low");
	a_last_byte_nack: assert property ( // R09
		(state_reg == ST_BIT && bit_reg == ACK_BIT_IDX && rx_role && left_reg == 8'h01
			&& phase_reg != PH_LOW) |-> !sda_oe_reg)
		else $error("last read byte not left unacknowledged");
	a_dir_bit_value: assert property ( // R11
		(state_reg == ST_BIT && bit_reg == LAST_DATA_BIT && phase_reg != PH_LOW
			&& role_reg inside {ROLE_ADDR_W, ROLE_ADDR_R})
			|-> (sda_oe_reg == (role_reg == ROLE_ADDR_W)))
		else $error("direction bit wrong");
	a_write_reg_next: assert property ( // R13
		(byte_end && role_reg == ROLE_ADDR_W && ack_lo_reg && !abort_reg)
			|=> (role_reg == ROLE_REG && tx_reg == reg_addr_reg))
		else $error("register address did not follow write address");
	a_write_ends_stop: assert property ( // R15
		(byte_end && role_reg == ROLE_WDATA && left_reg == 8'h01) |=> (state_reg == ST_STOP))
		else $error("write not closed by stop");
	a_read_rstart: assert property ( // R16
		(byte_end && role_reg == ROLE_REG && !wr_mode_reg && ack_lo_reg && !abort_reg)
			|=> (state_reg == ST_RSTART))
		else $error("read without repeated start");
	a_read_ends_stop: assert property ( // R18
		(byte_end && rx_role && left_reg == 8'h01) |=> (state_reg == ST_STOP) ##1 (state_reg == ST_STOP))
		else $error("read not closed by stop");

	c_write_done: cover property (done_reg && wr_mode_reg && !abort_reg);
	c_read_done: cover property (done_reg && !wr_mode_reg && !abort_reg);
	c_addr_nack: cover property (byte_end && role_reg == ROLE_ADDR_W && !ack_lo_reg);
	c_write_stall: cover property (need_wr_reg [*3]);
endmodule
`default_nettype wire

// file: rtl/pic_pkg.sv
/*
 * Shared constants and types for the two-wire register controller.
 * Assumes a 100 MHz system clock; the serial clock is derived from it.
 */
`default_nettype none
package pic_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Quarter of a 100 kHz serial clock period
	localparam int unsigned T_QUARTER_NS = 2500;
	localparam int unsigned QTR_CYC = (T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] DEV_ADDR = 7'h7e;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic [3:0] ACK_BIT_IDX = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [1:0] PH_LOW = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_RSTART, ST_STOP} pic_state_t;
	typedef enum logic [2:0] {ROLE_ADDR_W, ROLE_REG, ROLE_WDATA, ROLE_ADDR_R, ROLE_RDATA} pic_role_t;
endpackage
`default_nettype wire

// file: rtl/pic_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous input that idles at the reset level.
 */
`timescale 1ns/1ps
`default_nettype none
module pic_sync
	import pic_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic sync_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s1_reg <= LINE_IDLE;
			s2_reg <= LINE_IDLE;
			s3_reg <= LINE_IDLE;
		end
		else
		begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Change accepted once second and third agree
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sync_reg <= LINE_IDLE;
		else if (s2_reg == s3_reg)
			sync_reg <= s3_reg;
	end

	assign sync_o = sync_reg;
endmodule
`default_nettype wire

// file: test/pic_dev_model.sv
/*
 * Behavioural two-wire register device for the controller bench.
 * Assumes both lines are resolved by the bench with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module pic_dev_model
(
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [6:0] own_addr_i,
	output logic pull_o
);
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic [7:0] ptr;
	logic [2:0] ph;
	logic act;
	logic rd;
	logic mack;
	int n;
	initial
	begin
		for (int a = 0; a < 256; a++)
			mem[a] = {a[3:0], a[7:4]} ^ 8'ha5;
		pull_o = 1'b0;
		act = 1'b0;
		ph = 3'h4;
		n = 0;
	end
	always @(negedge sda_i)
		if (scl_i)
		begin
			act = 1'b1;
			// Clock fall closing the start is not a data bit
			n = -1;
			ph = 3'h0;
			pull_o = 1'b0;
		end
	always @(posedge sda_i)
		if (scl_i)
		begin
			act = 1'b0;
			pull_o = 1'b0;
		end
	// sampled while clock high, MSB first
	always @(posedge scl_i)
		if (act && n < 8 && ph != 3'h3)
			sh = {sh[6:0], sda_i};
		else if (act && n == 8)
			mack = ~sda_i;
	// only data pulled, on clock low
	always @(negedge scl_i)
		if (act)
		begin
			pull_o = 1'b0;
			if (n == 7)
			begin
				if (ph == 3'h0 && sh[7:1] == own_addr_i)
					rd = sh[0];
				else if (ph == 3'h0)
					ph = 3'h4;
				else if (ph == 3'h1)
					ptr = sh;
				else if (ph == 3'h2)
				begin
					mem[ptr] = sh;
					ptr = ptr + 8'h1;
				end
				pull_o = (ph < 3'h3);
			end
			else if (n == 8)
			begin
				// In a read the pointer moves only on a master ack, not on the first byte
				if (ph == 3'h3 && mack)
					ptr = ptr + 8'h1;
				else if (ph == 3'h3)
					ph = 3'h4;
				else if (ph == 3'h0)
					ph = rd ? 3'h3 : 3'h1;
				else if (ph == 3'h1)
					ph = 3'h2;
				if (ph == 3'h3)
					sh = mem[ptr];
			end
			else if (ph == 3'h3)
				sh = {sh[6:0], 1'b0};
			n = (n == 8) ? 0 : n + 1;
			if (ph == 3'h3 && n < 8)
				pull_o = ~sh[7];
		end
endmodule
`default_nettype wire

// file: test/tb_pic_master.sv
/*
 * Self-checking bench for the two-wire register controller.
 * Assumes the device model on the far side and pull-ups on both lines.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_pic_master;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic cmd_write_i = 1'b0;
	logic [7:0] cmd_reg_i = 8'h0;
	logic [7:0] cmd_len_i = 8'h0;
	logic [7:0] wr_data_i = 8'h0;
	logic wr_valid_i = 1'b0;
	logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, err_o, busy_o;
	logic sda_o, sda_oe_o, scl_o, scl_oe_o, dev_pull;
	logic [7:0] rd_data_o;
	logic [6:0] own_addr = 7'h7e;
	logic [7:0] shadow [256];
	logic [7:0] r;
	wire logic scl;
	wire logic sda;
	int failures = 0;
	int n_compared = 0;
	int seed_v;
	// Open-drain resolution with pull-ups
	assign scl = ~scl_oe_o;
	assign sda = ~(sda_oe_o | dev_pull);
	pic_master #(.QTR_CYCLES(8)) pic_master_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_reg_i(cmd_reg_i),
		.cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .done_o(done_o), .err_o(err_o), .busy_o(busy_o),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
	pic_dev_model pic_dev_model_i (.scl_i(scl), .sda_i(sda), .own_addr_i(own_addr),
		.pull_o(dev_pull));
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [7:0] init_val(input logic [7:0] a);
		return {a[3:0], a[7:4]} ^ 8'ha5;
	endfunction
	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Entered just after a falling edge; drives on falling edges only
	task automatic xfer(input logic w, input logic [7:0] rg, input logic [7:0] len,
		input logic e_err);
		int t;
		logic [7:0] nb;
		logic [7:0] nexp;
		logic [7:0] d;
		t = 0;
		nb = 8'h0;
		nexp = e_err ? 8'h0 : ((len == 8'h0) ? 8'h1 : len);
		cmd_write_i = w;
		cmd_reg_i = rg;
		cmd_len_i = len;
		cmd_valid_i = 1'b1;
		// Ready looked at mid-cycle, so the next rising edge takes the command
		while (cmd_ready_o !== 1'b1)
			@(negedge clk_i);
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		`CHK("busy", 1'b1, busy_o)
		while (done_o !== 1'b1 && t < 5000)
		begin
			@(negedge clk_i);
			t++;
			if (wr_valid_i)
				wr_valid_i = 1'b0;
			else if (wr_ready_o === 1'b1)
			begin
				d = 8'($urandom);
				wr_data_i = d;
				wr_valid_i = 1'b1;
				if (!e_err)
					shadow[8'(rg + nb)] = d;
				nb++;
			end
			if (rd_valid_o === 1'b1)
			begin
				`CHK("rd_data", shadow[8'(rg + nb)], rd_data_o)
				nb++;
			end
		end
		if (t >= 5000)
			failures++;
		`CHK("err", e_err, err_o)
		`CHK("bytes", nexp, nb)
		`CHK("scl_idle", 1'b1, scl)
		`CHK("sda_idle", 1'b1, sda)
		`CHK("busy_end", 1'b0, busy_o)
		`CHK("drv_level", 2'b00, {sda_o, scl_o})
		@(negedge clk_i);
		`CHK("ready", 1'b1, cmd_ready_o)
	endtask
	initial
	begin
		seed_v = $urandom(32'hc5623fcb);
		for (int a = 0; a < 256; a++)
			shadow[a] = init_val(8'(a));
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		arst_n_i = 1'b1;
		@(negedge clk_i);
		r = 8'($urandom);
		xfer(1'b1, r, 8'h1, 1'b0);
		xfer(1'b0, r, 8'h1, 1'b0);
		xfer(1'b1, 8'hfe, 8'h4, 1'b0);
		xfer(1'b0, 8'hfd, 8'h6, 1'b0);
		// Foreign address leaves the device untouched
		own_addr = 7'h3f;
		xfer(1'b1, 8'h10, 8'h2, 1'b1);
		xfer(1'b0, 8'h10, 8'h1, 1'b1);
		own_addr = 7'h7e;
		xfer(1'b0, 8'h10, 8'h2, 1'b0);
		xfer(1'b0, 8'h20, 8'h0, 1'b0);
		repeat (6)
		begin
			r = 8'($urandom);
			xfer(1'($urandom), r, 8'($urandom % 4), 1'b0);
		end
		end_of_test;
	end
	initial
	begin
		#500000;
		failures++;
		end_of_test;
	end
endmodule
`default_nettype wire
